//--- shared/env_sensor_pkg.sv
// Constants, register map and link states of the sensor result block
package env_sensor_pkg;
    // Register offsets on the serial pointer
    localparam logic [7:0] OFS_TEMP_LOW  = 8'h00;
    localparam logic [7:0] OFS_TEMP_HIGH = 8'h01;
    localparam logic [7:0] OFS_HUM_LOW   = 8'h02;
    localparam logic [7:0] OFS_HUM_HIGH  = 8'h03;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_TEMP_PEAK = 8'h05;
    localparam logic [7:0] OFS_HUM_PEAK  = 8'h06;
    localparam logic [7:0] OFS_EVENT_EN  = 8'h07;
    // Reset values
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [4:0]  FLAGS_RESET  = 5'h00;
    // Status layout: five flags in bits 7..3
    localparam int         FLAG_COUNT  = 5;
    localparam int         FLAG_LSB    = 3;
    localparam int         FLAG_CONV   = 4;
    localparam logic [2:0] STATUS_RSVD = 3'h0;
    localparam logic [7:0] EVENT_MASK  = 8'hF8;
    // Serial link
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h40;
    localparam logic [3:0] BYTE_BITS       = 4'h8;
    localparam logic [3:0] ONE_BIT         = 4'h1;
    localparam int         RESULT_BITS     = 16;
    localparam int         CODE_BITS_DOC   = 14;
    localparam int         PEAK_BITS       = 8;
    typedef enum logic [3:0] {
        IDLE,
        ADDR,
        ADDR_ACK,
        REG,
        REG_ACK,
        WDATA,
        WDATA_ACK,
        RDATA,
        RDATA_ACK
    } link_state_t;
endpackage

//--- logic/env_sensor_result_status_regs.sv
// Result, peak and event status registers behind a serial slave link
`timescale 1ns/1ps
`default_nettype none
module env_sensor_result_status_regs
    import env_sensor_pkg::*;
#(
    parameter int CODE_BITS = CODE_BITS_DOC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 link_clk,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_n,
    input  wire logic                 addr_sel,
    input  wire logic                 conv_done,
    input  wire logic                 conv_has_temp,
    input  wire logic                 conv_has_hum,
    input  wire logic [CODE_BITS-1:0] temp_code,
    input  wire logic [CODE_BITS-1:0] hum_code,
    input  wire logic                 temp_over_hit,
    input  wire logic                 temp_under_hit,
    input  wire logic                 hum_over_hit,
    input  wire logic                 hum_under_hit,
    input  wire logic                 auto_sample_mode,
    input  wire logic                 software_reset_bit,
    input  wire logic                 event_pin_en,
    input  wire logic                 event_pol,
    input  wire logic                 event_mode,
    output logic                      event_pin
);
    // Code must fill the peak byte and fit the result word
    generate
        if (CODE_BITS < PEAK_BITS || CODE_BITS > RESULT_BITS) begin : g_bad
            $error("CODE_BITS out of range");
        end
    endgenerate

    // ---- Link domain ----

    // Reset carried into the link domain; link_clk must run in reset
    logic [1:0] rst_l;
    logic       link_rst;
    assign link_rst = rst_l[1];
    always_ff @(posedge link_clk) begin
        rst_l <= {rst_l[0], rst};
    end

    // Pin synchronisers; only stages 1 and 2 feed logic
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] sel_s;
    always_ff @(posedge link_clk) begin
        scl_s <= {scl_s[1:0], scl_in};
        sda_s <= {sda_s[1:0], sda_in};
        sel_s <= {sel_s[0], addr_sel};
    end

    wire scl_rise   = scl_s[1] & ~scl_s[2];
    wire scl_fall   = ~scl_s[1] & scl_s[2];
    wire scl_steady = scl_s[1] & scl_s[2];
    wire start_seen = scl_steady & sda_s[2] & ~sda_s[1];
    wire stop_seen  = scl_steady & ~sda_s[2] & sda_s[1];

    link_state_t state;
    link_state_t next_state;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic [7:0]  ptr;
    logic [7:0]  next_ptr;
    logic        rd_dir;
    logic        next_dir;
    logic        next_oe_n;
    logic        fire;
    logic        fire_wr;
    logic        req_tgl;
    logic        req_wr;
    logic [7:0]  req_addr;
    logic [7:0]  req_wdata;
    logic [1:0]  ack_s;
    logic [7:0]  rdata;

    // Decode of the received byte and the pointer
    wire [6:0] own_addr = {SLAVE_ADDR_BASE[6:1], sel_s[1]};
    wire       byte_in  = (cnt == BYTE_BITS);
    wire       addr_hit = (shift[7:1] == own_addr);
    wire       ptr_ok   = (shift <= OFS_EVENT_EN);
    wire       busy     = (ack_s[1] != req_tgl);
    wire       wr_ok    = (ptr >= OFS_TEMP_PEAK) && (ptr <= OFS_EVENT_EN) && !busy;
    wire [7:0] ptr_inc  = ptr + 8'h01;

    // Byte engine: sample on SCL rise, drive on SCL fall
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_shift = shift;
        next_ptr   = ptr;
        next_dir   = rd_dir;
        next_oe_n  = sda_oe_n;
        fire       = 1'b0;
        fire_wr    = 1'b0;
        if (start_seen) begin
            next_state = ADDR;
            next_cnt   = 4'h0;
            next_oe_n  = 1'b1;
        end else if (stop_seen) begin
            next_state = IDLE;
            next_oe_n  = 1'b1;
        end else begin
            unique case (state)
                IDLE: begin
                    next_oe_n = 1'b1;
                end
                ADDR, REG, WDATA: begin
                    if (scl_rise && !byte_in) begin
                        next_shift = {shift[6:0], sda_s[1]};
                        next_cnt   = cnt + ONE_BIT;
                    end else if (scl_fall && byte_in) begin
                        next_cnt   = 4'h0;
                        next_state = IDLE;
                        if (state == ADDR && addr_hit) begin
                            next_oe_n  = 1'b0;
                            next_state = ADDR_ACK;
                            next_dir   = shift[0];
                            // First read byte fetched during the ack bit
                            if (shift[0] && !busy) begin
                                fire     = 1'b1;
                                next_ptr = ptr_inc;
                            end
                        end else if (state == REG && ptr_ok) begin
                            next_oe_n  = 1'b0;
                            next_state = REG_ACK;
                            next_ptr   = shift;
                        end else if (state == WDATA && wr_ok) begin
                            next_oe_n  = 1'b0;
                            next_state = WDATA_ACK;
                            fire       = 1'b1;
                            fire_wr    = 1'b1;
                            next_ptr   = ptr_inc;
                        end
                    end
                end
                ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rd_dir) begin
                            next_shift = {rdata[6:0], 1'b0};
                            next_oe_n  = rdata[7];
                            next_cnt   = ONE_BIT;
                            next_state = RDATA;
                        end else begin
                            next_oe_n  = 1'b1;
                            next_state = REG;
                        end
                    end
                end
                REG_ACK, WDATA_ACK: begin
                    if (scl_fall) begin
                        next_oe_n  = 1'b1;
                        next_state = WDATA;
                    end
                end
                RDATA: begin
                    if (scl_fall) begin
                        if (byte_in) begin
                            next_oe_n  = 1'b1;
                            next_cnt   = 4'h0;
                            next_state = RDATA_ACK;
                        end else begin
                            next_oe_n  = shift[7];
                            next_shift = {shift[6:0], 1'b0};
                            next_cnt   = cnt + ONE_BIT;
                        end
                    end
                end
                RDATA_ACK: begin
                    // Fetch only on a master ack, so a NACK has no side effect
                    if (scl_rise && !sda_s[1] && !busy) begin
                        fire     = 1'b1;
                        next_ptr = ptr_inc;
                        next_cnt = ONE_BIT;
                    end else if (scl_fall) begin
                        next_state = (cnt == ONE_BIT) ? RDATA : IDLE;
                        next_shift = {rdata[6:0], 1'b0};
                        next_oe_n  = (cnt == ONE_BIT) ? rdata[7] : 1'b1;
                    end
                end
            endcase
        end
    end

    // Link state registers
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state    <= IDLE;
            cnt      <= 4'h0;
            shift    <= BYTE_RESET;
            ptr      <= BYTE_RESET;
            rd_dir   <= 1'b0;
            sda_oe_n <= 1'b1;
            sda_out  <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            shift    <= next_shift;
            ptr      <= next_ptr;
            rd_dir   <= next_dir;
            sda_oe_n <= next_oe_n;
            sda_out  <= 1'b0;
        end
    end

    // Request words stay put until the next toggle
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            req_tgl   <= 1'b0;
            req_wr    <= 1'b0;
            req_addr  <= BYTE_RESET;
            req_wdata <= BYTE_RESET;
        end else if (fire) begin
            req_tgl   <= ~req_tgl;
            req_wr    <= fire_wr;
            req_addr  <= ptr;
            req_wdata <= shift;
        end
    end

    // Completion toggle back from the register side
    logic ack_tgl;
    always_ff @(posedge link_clk) begin
        ack_s <= {ack_s[0], ack_tgl};
    end

    // ---- Register domain ----

    logic       core_rst;
    logic [2:0] req_s;
    assign core_rst = rst | software_reset_bit;
    always_ff @(posedge ref_clk) begin
        req_s <= {req_s[1:0], req_tgl};
    end

    // Request fields are stable once the toggle is seen here
    wire acc_fire = req_s[1] ^ req_s[2];
    wire acc_rd   = acc_fire & ~req_wr;
    wire acc_wr   = acc_fire & req_wr;
    wire rd_stat  = acc_rd && (req_addr == OFS_STATUS);
    wire rd_res   = acc_rd && (req_addr <= OFS_HUM_HIGH);

    logic [15:0]           temp_res;
    logic [15:0]           hum_res;
    logic [7:0]            temp_peak;
    logic [7:0]            hum_peak;
    logic [7:0]            event_enable;
    logic [FLAG_COUNT-1:0] flags;
    logic [FLAG_COUNT-1:0] hit_prev;

    // Codes left-justified in 16 bits, unused low bits zero
    wire [15:0] temp_word = RESULT_BITS'({temp_code, (RESULT_BITS-CODE_BITS)'(0)});
    wire [15:0] hum_word  = RESULT_BITS'({hum_code, (RESULT_BITS-CODE_BITS)'(0)});
    wire        temp_new  = conv_done & conv_has_temp;
    wire        hum_new   = conv_done & conv_has_hum;

    // Both bytes of a result load on one edge
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            temp_res <= RESULT_RESET;
            hum_res  <= RESULT_RESET;
        end else begin
            if (temp_new) temp_res <= temp_word;
            if (hum_new) hum_res <= hum_word;
        end
    end

    // Peak is the result's top byte, same scale as the word
    wire [7:0] temp_top = temp_word[15:8];
    wire [7:0] hum_top  = hum_word[15:8];
    wire       peak_ok  = ~auto_sample_mode;
    wire       t_grow   = temp_new && peak_ok && (temp_top > temp_peak);
    wire       h_grow   = hum_new && peak_ok && (hum_top > hum_peak);

    // Host write wins over a tracked peak in the same cycle
    always_ff @(posedge ref_clk) begin
        if (core_rst) begin
            temp_peak <= BYTE_RESET;
            hum_peak  <= BYTE_RESET;
        end else begin
            if (acc_wr && req_addr == OFS_TEMP_PEAK) temp_peak <= req_wdata;
            else if (t_grow) temp_peak <= temp_top;
            if (acc_wr && req_addr == OFS_HUM_PEAK) hum_peak <= req_wdata;
            else if (h_grow) hum_peak <= hum_top;
        end
    end

    // Enable bits 2..0 are not stored
    always_ff @(posedge ref_clk) begin
        if (core_rst) event_enable <= BYTE_RESET;
        else if (acc_wr && req_addr == OFS_EVENT_EN) event_enable <= req_wdata & EVENT_MASK;
    end

    // Flag sources, conversion first, then the four thresholds
    wire [FLAG_COUNT-1:0] hit_lvl = {
        conv_done & (conv_has_temp | conv_has_hum),
        temp_over_hit,
        temp_under_hit,
        hum_over_hit,
        hum_under_hit
    };
    wire [FLAG_COUNT-1:0] flag_en = event_enable[7:FLAG_LSB];

    // Per-flag set and clear; a set in the clearing cycle survives
    genvar i;
    generate
        for (i = 0; i < FLAG_COUNT; i++) begin : g_flag
            wire edge_hit = hit_lvl[i] & ~hit_prev[i];
            // Mode 1 re-arms while a threshold stays crossed
            wire src = (i == FLAG_CONV || !event_mode) ? edge_hit : hit_lvl[i];
            wire set = flag_en[i] & src;
            wire clr = rd_stat | ((i == FLAG_CONV) & rd_res);
            always_ff @(posedge ref_clk) begin
                if (core_rst) begin
                    flags[i]    <= 1'b0;
                    hit_prev[i] <= 1'b0;
                end else begin
                    flags[i]    <= (flags[i] & ~clr) | set;
                    hit_prev[i] <= (i == FLAG_CONV) ? 1'b0 : hit_lvl[i];
                end
            end
        end
    endgenerate

    // Read selection; the status byte is taken before its clear
    wire [7:0] status_byte = {flags, STATUS_RSVD};
    wire [7:0] rd_mux =
        (req_addr == OFS_TEMP_LOW)  ? temp_res[7:0]  :
        (req_addr == OFS_TEMP_HIGH) ? temp_res[15:8] :
        (req_addr == OFS_HUM_LOW)   ? hum_res[7:0]   :
        (req_addr == OFS_HUM_HIGH)  ? hum_res[15:8]  :
        (req_addr == OFS_STATUS)    ? status_byte    :
        (req_addr == OFS_TEMP_PEAK) ? temp_peak      :
        (req_addr == OFS_HUM_PEAK)  ? hum_peak       :
        (req_addr == OFS_EVENT_EN)  ? event_enable   : BYTE_RESET;

    // Read data held for the link until the next request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata   <= BYTE_RESET;
            ack_tgl <= 1'b0;
        end else if (acc_fire) begin
            if (!req_wr) rdata <= rd_mux;
            ack_tgl <= ~ack_tgl;
        end
    end

    // Pin shows any raised flag, polarity chosen outside
    wire any_flag = event_pin_en & (|flags);
    always_ff @(posedge ref_clk) begin
        if (core_rst) event_pin <= 1'b0;
        else event_pin <= any_flag ? event_pol : ~event_pol;
    end

    // ---- Checks ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (core_rst);

    sequence s_status_read;
        rd_stat && !(|(flag_en & hit_lvl));
    endsequence

    a_temp_result_load: assert property (temp_new |=>
        temp_res == {$past(temp_code), 2'b00})
        else $error("temperature result not loaded");
    a_hum_result_load: assert property (hum_new |=>
        hum_res == {$past(hum_code), 2'b00})
        else $error("humidity result not loaded");
    a_status_read_value: assert property (rd_stat |=>
        rdata == {$past(flags), 3'b000})
        else $error("status byte wrong");
    a_conv_flag_set: assert property (hit_lvl[4] && flag_en[4] |=>
        flags[4])
        else $error("conversion flag not set");
    a_conv_flag_clear: assert property (rd_res && !hit_lvl[4] |=>
        !flags[4])
        else $error("conversion flag not cleared");
    a_status_clears: assert property (s_status_read |=>
        flags == 5'h00)
        else $error("status read left a flag");
    a_set_wins: assert property (rd_stat && flag_en[3] && hit_lvl[3] &&
        !hit_prev[3] |=> flags[3])
        else $error("event lost during read");
    a_enable_gate: assert property (!flag_en[3] && !flags[3] && !rd_stat |=>
        !flags[3])
        else $error("disabled flag was set");
    a_temp_peak_grow: assert property (t_grow && !acc_wr |=>
        temp_peak == $past(temp_code[CODE_BITS-1 -: 8]))
        else $error("temperature peak not tracked");
    a_peak_auto_hold: assert property (auto_sample_mode && !acc_wr |=>
        $stable(temp_peak) && $stable(hum_peak))
        else $error("peak moved in auto mode");
    a_pin_follow: assert property (event_pin_en && (|flags) |=>
        event_pin == $past(event_pol))
        else $error("event pin not asserted");
    a_nack_bad_ptr: assert property (@(posedge link_clk) disable iff (link_rst)
        state == REG && scl_fall && byte_in && !ptr_ok && !start_seen && !stop_seen
        |=> state == IDLE && sda_oe_n)
        else $error("bad pointer was acknowledged");
endmodule
`default_nettype wire

//--- tb/sensor_host_model.sv
// Bit-banged serial host that reads and writes the sensor registers
`timescale 1ns/1ps
`default_nettype none
module sensor_host_model #(
    parameter logic [6:0] DEV = 7'h41
) (
    output logic      scl,
    output wire logic sda,
    input  wire logic dev_sda_oe_n,
    input  wire logic dev_sda_out
);
    // Quarter of a 10 us bit: the fastest rate the slave is built for
    localparam int Q = 2500;
    logic sda_r;
    // Pulled-up line, low whenever either party pulls it
    assign sda = sda_r & (dev_sda_oe_n | dev_sda_out);
    initial begin
        scl = 1'b1;
        sda_r = 1'b1;
    end
    // One bit: data moves only while the clock is low
    task automatic clk_bit(input logic d, output logic s);
        sda_r = d;
        #Q;
        scl = 1'b1;
        #Q;
        s = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    // Eight bits plus the acknowledge slot, MSB first
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
    endtask
    // Also serves as repeated start: clock is low on entry then
    task automatic start_cond();
        sda_r = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_r = 1'b0;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    task automatic stop_cond();
        sda_r = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_r = 1'b1;
        #Q;
    endtask
    // Bytes are sent even after a refusal; the slave ignores them
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, data,
                             output logic [2:0] acks);
        logic [8:0] r0, r1, r2;
        start_cond();
        byte_io({dev, 2'b01}, r0);
        byte_io({ptr, 1'b1}, r1);
        byte_io({data, 1'b1}, r2);
        stop_cond();
        acks = ~{r0[0], r1[0], r2[0]};
    endtask
    // Ascending burst, so each low byte comes before its high byte
    task automatic read_burst(input logic [7:0] ptr, input int n,
                              output logic [7:0] d [8], output logic ok);
        logic [8:0] r0, r1, r2, rx;
        start_cond();
        byte_io({DEV, 2'b01}, r0);
        byte_io({ptr, 1'b1}, r1);
        start_cond();
        byte_io({DEV, 2'b11}, r2);
        for (int i = 0; i < n; i++) begin
            byte_io({8'hFF, i == n - 1}, rx);
            d[i] = rx[8:1];
        end
        stop_cond();
        ok = ~(r0[0] | r1[0] | r2[0]);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the sensor result, peak and status registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import env_sensor_pkg::*;
    localparam logic [6:0] DEV = {SLAVE_ADDR_BASE[6:1], 1'b1};
    logic                     ref_clk, link_clk, rst, scl, sda_out, sda_oe_n, event_pin;
    logic                     conv_done, auto_mode, soft_rst, pol, ev_mode, ok, pin_en;
    wire logic                sda;
    logic [CODE_BITS_DOC-1:0] t_code, h_code;
    logic [3:0]               hits;
    logic [2:0]               acks;
    logic [7:0]               rd [8];
    int                       n_errors, compares;
    // Register clock and an unrelated link clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    env_sensor_result_status_regs u_dut (
        .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(1'b1), .conv_done(conv_done),
        .conv_has_temp(1'b1), .conv_has_hum(1'b1), .temp_code(t_code), .hum_code(h_code),
        .temp_over_hit(hits[3]), .temp_under_hit(hits[2]), .hum_over_hit(hits[1]),
        .hum_under_hit(hits[0]), .auto_sample_mode(auto_mode), .software_reset_bit(soft_rst),
        .event_pin_en(pin_en), .event_pol(pol), .event_mode(ev_mode), .event_pin(event_pin)
    );
    sensor_host_model #(.DEV(DEV)) u_host (
        .scl(scl), .sda(sda), .dev_sda_oe_n(sda_oe_n), .dev_sda_out(sda_out)
    );
    // Inputs always move 2 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk_byte(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pin_is(input logic exp);
        chk_byte({7'h0, event_pin}, {7'h0, exp});
    endtask
    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp [8], input int n);
        u_host.read_burst(ptr, n, rd, ok);
        chk_byte({7'h0, ok}, 8'h01);
        for (int i = 0; i < n; i++) begin
            chk_byte(rd[i], exp[i]);
        end
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, d, input logic [2:0] ea);
        u_host.write_reg(dev, ptr, d, acks);
        chk_byte({5'h0, acks}, {5'h0, ea});
    endtask
    task automatic convert(input logic [CODE_BITS_DOC-1:0] t, h);
        t_code = t;
        h_code = h;
        conv_done = 1'b1;
        tick(1);
        conv_done = 1'b0;
        tick(3);
    endtask
    task automatic t_reset_vals();
        rd_chk(OFS_TEMP_LOW, '{default: BYTE_RESET}, 8);
        pin_is(~pol);
        $display("test reset_vals done");
    endtask
    // Wrong address, missing register, write to a read-only result
    task automatic t_refusals();
        wr(7'h40, OFS_STATUS, 8'h00, 3'b000);
        wr(DEV, 8'h08, 8'h00, 3'b100);
        wr(DEV, OFS_TEMP_LOW, 8'h55, 3'b110);
        $display("test refusals done");
    endtask
    task automatic t_enable();
        hits = 4'hF;
        tick(3);
        hits = 4'h0;
        tick(2);
        rd_chk(OFS_STATUS, '{default: 8'h00}, 1);
        wr(DEV, OFS_EVENT_EN, 8'hFF, 3'b111);
        rd_chk(OFS_EVENT_EN, '{default: EVENT_MASK}, 1);
        $display("test enable done");
    endtask
    // Reading a result byte drops the ready flag before status is reached
    task automatic t_conversion();
        convert(14'h2ABC, 14'h1234);
        pin_is(pol);
        rd_chk(OFS_TEMP_LOW, '{8'hF0, 8'hAA, 8'hD0, 8'h48, 8'h00, 0, 0, 0}, 5);
        pin_is(~pol);
        convert(14'h1000, 14'h0800);
        rd_chk(OFS_STATUS, '{default: 8'h80}, 1);
        rd_chk(OFS_STATUS, '{default: 8'h00}, 1);
        $display("test conversion done");
    endtask
    // Smaller and auto-mode conversions must leave both peaks alone
    task automatic t_peaks();
        auto_mode = 1'b1;
        convert(14'h3FFF, 14'h3F00);
        auto_mode = 1'b0;
        rd_chk(OFS_TEMP_LOW, '{8'hFC, 8'hFF, 8'h00, 8'hFC, 8'h00, 8'hAA, 8'h48, 0}, 7);
        wr(DEV, OFS_TEMP_PEAK, 8'h10, 3'b111);
        rd_chk(OFS_TEMP_PEAK, '{default: 8'h10}, 1);
        $display("test peaks done");
    endtask
    task automatic t_thresholds();
        logic [7:0] e;
        for (int i = 0; i < 4; i++) begin
            hits = 4'h8 >> i;
            e = {1'b0, hits, 3'h0};
            tick(3);
            hits = 4'h0;
            tick(2);
            rd_chk(OFS_STATUS, '{default: e}, 1);
        end
        ev_mode = 1'b1;
        hits = 4'hF;
        tick(3);
        rd_chk(OFS_STATUS, '{default: 8'h78}, 1);
        rd_chk(OFS_STATUS, '{default: 8'h78}, 1);
        // Flags still raised, so only the pin enable can hide them
        pin_is(pol);
        pin_en = 1'b0;
        tick(3);
        pin_is(~pol);
        pin_en = 1'b1;
        hits = 4'h0;
        ev_mode = 1'b0;
        $display("test thresholds done");
    endtask
    task automatic t_soft_reset();
        soft_rst = 1'b1;
        tick(3);
        pin_is(1'b0);
        soft_rst = 1'b0;
        tick(3);
        rd_chk(OFS_STATUS, '{default: BYTE_RESET}, 4);
        pin_is(~pol);
        $display("test soft_reset done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole sequence needs about 91k register clocks
    initial begin
        repeat (130000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        conv_done = 1'b0;
        t_code = '0;
        h_code = '0;
        hits = 4'h0;
        auto_mode = 1'b0;
        soft_rst = 1'b0;
        pol = 1'b1;
        pin_en = 1'b1;
        ev_mode = 1'b0;
        tick(12);
        rst = 1'b0;
        tick(4);
        t_reset_vals();
        t_refusals();
        t_enable();
        t_conversion();
        t_peaks();
        t_thresholds();
        t_soft_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
